// file: src/frisa_consts.svh
// Constants for the file-register increment, OR and shift datapath.
// Assumes inclusion by bare name from the design files under src/.
`ifndef FRISA_CONSTS_SVH
`define FRISA_CONSTS_SVH

// Reset values
`define FRISA_ACC_RST    8'h00
`define FRISA_RESULT_RST 8'h00
`define FRISA_ZERO_RST   1'b0
`define FRISA_CARRY_RST  1'b0

// Destination select encodings
`define FRISA_DEST_ACC   1'b0
`define FRISA_DEST_FILE  1'b1

// Documented operand width and file address width
`define FRISA_DATA_W     8
`define FRISA_ADDR_W     7

// Increment step
`define FRISA_INC_STEP   1

`endif

// file: src/frisa_pkg.sv
// Types for the file-register increment, OR and shift datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package frisa_pkg;

  typedef enum logic [1:0] {
    increment_file_op           = 2'h0,
    or_accumulator_with_file_op = 2'h1,
    shift_left_logical_op       = 2'h2,
    shift_right_logical_op      = 2'h3
  } frisa_op_t;

endpackage : frisa_pkg

// file: src/frisa_alu_if.sv
// Carrier between the datapath top and its arithmetic unit.
// Assumes both ends use the same data width.
`timescale 1ns/1ps
interface frisa_alu_if #(
  parameter int DATA_W = 8
);
  frisa_pkg::frisa_op_t op;
  logic [DATA_W-1:0]    operand;
  logic [DATA_W-1:0]    acc;
  logic [DATA_W-1:0]    result;
  logic                 carry_out;
  logic                 carry_upd;
  logic                 zero_out;

  modport ctrl (output op, output operand, output acc,
                input result, input carry_out, input carry_upd, input zero_out);
  modport unit (input op, input operand, input acc,
                output result, output carry_out, output carry_upd, output zero_out);
endinterface : frisa_alu_if

// file: src/frisa_alu_unit.sv
// Combinational arithmetic unit: increment, inclusive OR and logical shifts.
// Assumes the top registers result, carry and zero and uses carry_upd unregistered; nothing here holds state.
`timescale 1ns/1ps
`include "frisa_consts.svh"
module frisa_alu_unit #(
  parameter int DATA_W = 8
) (
  frisa_alu_if.unit alu
);

  // The shifts need a bit 1 to move from
  if (DATA_W < 2) begin : g_bad_data_w
    $error("frisa_alu_unit: DATA_W must be at least 2");
  end

  wire [DATA_W-1:0] inc_result;
  wire [DATA_W-1:0] or_result;
  wire [DATA_W-1:0] shl_result;
  wire [DATA_W-1:0] shr_result;
  wire              is_shl;
  wire              is_shr;

  // Plain width-limited sum: the top value wraps to zero
  assign inc_result = alu.operand + DATA_W'(`FRISA_INC_STEP);
  assign or_result  = alu.acc | alu.operand;
  assign shl_result = {alu.operand[DATA_W-2:0], 1'b0};
  assign shr_result = {1'b0, alu.operand[DATA_W-1:1]};

  assign is_shl = (alu.op == frisa_pkg::shift_left_logical_op);
  assign is_shr = (alu.op == frisa_pkg::shift_right_logical_op);

  assign alu.result = (alu.op == frisa_pkg::increment_file_op)           ? inc_result :
                      (alu.op == frisa_pkg::or_accumulator_with_file_op) ? or_result  :
                      is_shl                                             ? shl_result :
                                                                           shr_result;

  // Only the shifts touch carry; increment and OR leave it alone
  assign alu.carry_upd = is_shl | is_shr;
  assign alu.carry_out = is_shl ? alu.operand[DATA_W-1] : alu.operand[0];
  assign alu.zero_out  = (alu.result == '0);

endmodule : frisa_alu_unit

// file: src/frisa_datapath.sv
// Execution datapath for the file-register increment, OR and shift instructions.
// Assumes decode presents one instruction per cycle with its file operand already read.
`timescale 1ns/1ps
`include "frisa_consts.svh"
module frisa_datapath #(
  parameter int DATA_W = `FRISA_DATA_W,
  parameter int ADDR_W = `FRISA_ADDR_W
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // Instruction request from decode
  input  wire logic                 op_valid_i,
  input  wire frisa_pkg::frisa_op_t op_code_i,
  input  wire logic                 dest_sel_i,
  input  wire logic [ADDR_W-1:0]    file_addr_i,
  input  wire logic [DATA_W-1:0]    file_data_i,
  // Accumulator load by other instructions
  input  wire logic                 acc_load_i,
  input  wire logic [DATA_W-1:0]    acc_load_data_i,
  // File register write-back
  output logic                      file_we_o,
  output logic [ADDR_W-1:0]         file_addr_o,
  output logic [DATA_W-1:0]         file_wdata_o,
  // Architectural state
  output logic [DATA_W-1:0]         acc_o,
  output logic                      zero_o,
  output logic                      carry_o,
  output logic                      done_o
);

  // Refused at elaboration, so a bad width never reaches simulation
  if (DATA_W < 2 || DATA_W > 8) begin : g_bad_data_w
    $error("frisa_datapath: DATA_W must lie between 2 and 8");
  end
  if (ADDR_W < 1) begin : g_bad_addr_w
    $error("frisa_datapath: ADDR_W must be at least 1");
  end

  frisa_alu_if #(.DATA_W(DATA_W)) alu ();

  frisa_alu_unit #(.DATA_W(DATA_W)) i_frisa_alu_unit (
    .alu (alu.unit)
  );

  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] result;
  logic [ADDR_W-1:0] addr;
  logic              file_we;
  logic              zero;
  logic              carry;
  logic              done;

  wire               to_acc;
  wire               to_file;
  wire [DATA_W-1:0]  next_acc;
  wire               next_carry;

  assign alu.op      = op_code_i;
  assign alu.operand = file_data_i;
  assign alu.acc     = acc;

  assign to_acc  = op_valid_i && (dest_sel_i == `FRISA_DEST_ACC);
  assign to_file = op_valid_i && (dest_sel_i == `FRISA_DEST_FILE);

  // An accumulator-destination result wins over a load from elsewhere in the same cycle
  assign next_acc   = to_acc     ? alu.result      :
                      acc_load_i ? acc_load_data_i : acc;
  assign next_carry = (op_valid_i && alu.carry_upd) ? alu.carry_out : carry;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc   <= DATA_W'(`FRISA_ACC_RST);
      carry <= `FRISA_CARRY_RST;
      zero  <= `FRISA_ZERO_RST;
    end else begin
      acc   <= next_acc;
      carry <= next_carry;
      if (op_valid_i) begin
        zero <= alu.zero_out;
      end
    end
  end

  // Write-back is one pulse a cycle after the request, paired with its address
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      result  <= DATA_W'(`FRISA_RESULT_RST);
      addr    <= '0;
      file_we <= 1'b0;
      done    <= 1'b0;
    end else begin
      file_we <= to_file;
      done    <= op_valid_i;
      if (op_valid_i) begin
        result <= alu.result;
        addr   <= file_addr_i;
      end
    end
  end

  assign file_we_o    = file_we;
  assign file_addr_o  = addr;
  assign file_wdata_o = result;
  assign acc_o        = acc;
  assign zero_o       = zero;
  assign carry_o      = carry;
  assign done_o       = done;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  wire is_inc = op_valid_i && (op_code_i == frisa_pkg::increment_file_op);
  wire is_or  = op_valid_i && (op_code_i == frisa_pkg::or_accumulator_with_file_op);
  wire is_shl = op_valid_i && (op_code_i == frisa_pkg::shift_left_logical_op);
  wire is_shr = op_valid_i && (op_code_i == frisa_pkg::shift_right_logical_op);

  property p_dest_acc;
    to_acc |=> !file_we_o && (acc_o == file_wdata_o);
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("accumulator destination not honoured");

  property p_dest_file;
    to_file && !acc_load_i |=> file_we_o && (file_addr_o == $past(file_addr_i))
                               && (acc_o == $past(acc_o));
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not honoured");

  property p_inc;
    is_inc |=> (file_wdata_o == DATA_W'($past(file_data_i) + 1)) && $stable(carry_o);
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment result or carry wrong");

  property p_or;
    is_or |=> (file_wdata_o == ($past(acc_o) | $past(file_data_i))) && $stable(carry_o);
  endproperty
  a_or: assert property (p_or)
    else $error("inclusive OR result or carry wrong");

  property p_shl_move;
    is_shl |=> (carry_o == $past(file_data_i[DATA_W-1]))
               && (file_wdata_o[DATA_W-1:1] == $past(file_data_i[DATA_W-2:0]));
  endproperty
  a_shl_move: assert property (p_shl_move)
    else $error("left shift move wrong");

  property p_shl_fill;
    is_shl |=> (file_wdata_o[0] == 1'b0) ##0 done_o;
  endproperty
  a_shl_fill: assert property (p_shl_fill)
    else $error("left shift fill bit not zero");

  property p_shr_move;
    is_shr |=> (carry_o == $past(file_data_i[0]))
               && (file_wdata_o[DATA_W-2:0] == $past(file_data_i[DATA_W-1:1]));
  endproperty
  a_shr_move: assert property (p_shr_move)
    else $error("right shift move wrong");

  property p_shr_fill;
    is_shr |=> (file_wdata_o[DATA_W-1] == 1'b0) ##0 done_o;
  endproperty
  a_shr_fill: assert property (p_shr_fill)
    else $error("right shift fill bit not zero");

  property p_zero;
    op_valid_i |=> (zero_o == (file_wdata_o == '0));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag does not match result");

  property p_flags_hold;
    !op_valid_i |=> $stable(zero_o) && $stable(carry_o) && !file_we_o;
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags moved without an instruction");

  property p_inc_wrap;
    is_inc && (file_data_i == '1) |=> zero_o && (file_wdata_o == '0);
  endproperty
  a_inc_wrap: assert property (p_inc_wrap)
    else $error("increment did not wrap to zero");

  property p_or_to_acc;
    is_or && to_acc |=> (acc_o == ($past(acc_o) | $past(file_data_i)));
  endproperty
  a_or_to_acc: assert property (p_or_to_acc)
    else $error("inclusive OR did not reach the accumulator");

  property p_load_taken;
    acc_load_i && !to_acc |=> (acc_o == $past(acc_load_data_i));
  endproperty
  a_load_taken: assert property (p_load_taken)
    else $error("accumulator load lost");

  property p_acc_hold;
    !to_acc && !acc_load_i |=> $stable(acc_o);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator moved without a write");

  property p_done_pulse;
    op_valid_i |=> done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done pulse missing after an instruction");

  c_inc_wrap_file: cover property (is_inc && to_file && (file_data_i == '1));
  c_shl_carry:     cover property (is_shl && file_data_i[DATA_W-1] ##1 is_shr);
  c_or_to_acc:     cover property (is_or && to_acc ##1 is_or && to_acc);
  c_load_collide:  cover property (to_acc && acc_load_i);

endmodule : frisa_datapath

// file: verification/frisa_datapath_tb.sv
// Self-checking bench for the increment, OR and shift datapath.
// Assumes the design files under src/ are compiled first; no partner model.
`timescale 1ns/1ps
module frisa_datapath_tb;
  logic                 clk_sys_i = 1'b0;
  logic                 rst_i     = 1'b1;
  logic                 op_valid_i = 1'b0;
  frisa_pkg::frisa_op_t op_code_i = frisa_pkg::increment_file_op;
  logic                 dest_sel_i = 1'b0;
  logic [6:0]           file_addr_i = 7'h00;
  logic [7:0]           file_data_i = 8'h00;
  logic                 acc_load_i = 1'b0;
  logic [7:0]           acc_load_data_i = 8'h00;
  logic                 file_we_o;
  logic [6:0]           file_addr_o;
  logic [7:0]           file_wdata_o;
  logic [7:0]           acc_o;
  logic                 zero_o;
  logic                 carry_o;
  logic                 done_o;
  int                   err_total = 0;
  int                   check_count = 0;
  logic [7:0]           exp_acc = 8'h00;
  logic                 exp_c = 1'b0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  frisa_datapath i_frisa_datapath (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .dest_sel_i(dest_sel_i), .file_addr_i(file_addr_i), .file_data_i(file_data_i),
    .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i), .file_we_o(file_we_o),
    .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o),
    .zero_o(zero_o), .carry_o(carry_o), .done_o(done_o));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Load acc through the side port so OR has a known operand
  task automatic load_acc(input logic [7:0] d);
    @(posedge clk_sys_i);
    acc_load_i      <= 1'b1;
    acc_load_data_i <= d;
    @(posedge clk_sys_i);
    acc_load_i <= 1'b0;
    exp_acc = d;
    #1;
    chk(acc_o, d);
  endtask : load_acc

  // One instruction; expectation worked out here, carry kept unless a shift
  task automatic run_op(input frisa_pkg::frisa_op_t op, input logic dst,
                        input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    case (op)
      frisa_pkg::increment_file_op:           r = d + 8'h01;
      frisa_pkg::or_accumulator_with_file_op: r = exp_acc | d;
      frisa_pkg::shift_left_logical_op: begin
        r     = {d[6:0], 1'b0};
        exp_c = d[7];
      end
      default: begin
        r     = {1'b0, d[7:1]};
        exp_c = d[0];
      end
    endcase
    if (!dst) exp_acc = r;
    @(posedge clk_sys_i);
    op_valid_i  <= 1'b1;
    op_code_i   <= op;
    dest_sel_i  <= dst;
    file_addr_i <= a;
    file_data_i <= d;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    #1;
    chk({7'h00, done_o}, 8'h01);
    chk({7'h00, file_we_o}, {7'h00, dst});
    chk({1'b0, file_addr_o}, {1'b0, a});
    chk(acc_o, exp_acc);
    chk(file_wdata_o, r);
    chk({7'h00, zero_o}, {7'h00, r == 8'h00});
    chk({7'h00, carry_o}, {7'h00, exp_c});
    @(posedge clk_sys_i);
    #1;
    chk({6'h00, done_o, file_we_o}, 8'h00);
  endtask : run_op

  task automatic t_increment();
    run_op(frisa_pkg::shift_left_logical_op, 1'b1, 7'h05, 8'h80);
    run_op(frisa_pkg::increment_file_op, 1'b1, 7'h7F, 8'h41);
    run_op(frisa_pkg::increment_file_op, 1'b0, 7'h00, 8'hFF);
  endtask : t_increment

  task automatic t_or();
    load_acc(8'h50);
    run_op(frisa_pkg::or_accumulator_with_file_op, 1'b1, 7'h2A, 8'h0A);
    run_op(frisa_pkg::or_accumulator_with_file_op, 1'b0, 7'h11, 8'h0A);
    load_acc(8'h00);
    run_op(frisa_pkg::or_accumulator_with_file_op, 1'b0, 7'h12, 8'h00);
  endtask : t_or

  task automatic t_shift_left();
    run_op(frisa_pkg::shift_left_logical_op, 1'b1, 7'h33, 8'h81);
    run_op(frisa_pkg::shift_left_logical_op, 1'b0, 7'h34, 8'h7F);
  endtask : t_shift_left

  task automatic t_shift_right();
    run_op(frisa_pkg::shift_right_logical_op, 1'b0, 7'h40, 8'h01);
    run_op(frisa_pkg::shift_right_logical_op, 1'b1, 7'h41, 8'hFE);
    run_op(frisa_pkg::shift_right_logical_op, 1'b1, 7'h42, 8'hFF);
  endtask : t_shift_right

  // Load beside an instruction: a dest-0 result wins, a dest-1 lets the load in
  task automatic t_collide();
    @(posedge clk_sys_i);
    op_valid_i      <= 1'b1;
    op_code_i       <= frisa_pkg::increment_file_op;
    dest_sel_i      <= 1'b0;
    file_addr_i     <= 7'h21;
    file_data_i     <= 8'h10;
    acc_load_i      <= 1'b1;
    acc_load_data_i <= 8'hA5;
    @(posedge clk_sys_i);
    dest_sel_i  <= 1'b1;
    file_addr_i <= 7'h22;
    file_data_i <= 8'h3C;
    #1;
    chk(acc_o, 8'h11);
    chk(file_wdata_o, 8'h11);
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    acc_load_i <= 1'b0;
    #1;
    chk(acc_o, 8'hA5);
    chk({7'h00, file_we_o}, 8'h01);
    chk({1'b0, file_addr_o}, 8'h22);
    chk(file_wdata_o, 8'h3D);
    chk({7'h00, zero_o}, 8'h00);
    exp_acc = 8'hA5;
  endtask : t_collide

  // Back-to-back issue: the second OR sees the accumulator the first one wrote
  task automatic t_back_to_back();
    load_acc(8'h01);
    @(posedge clk_sys_i);
    op_valid_i  <= 1'b1;
    op_code_i   <= frisa_pkg::or_accumulator_with_file_op;
    dest_sel_i  <= 1'b0;
    file_addr_i <= 7'h30;
    file_data_i <= 8'h02;
    @(posedge clk_sys_i);
    file_data_i <= 8'h04;
    #1;
    chk(acc_o, 8'h03);
    @(posedge clk_sys_i);
    op_code_i   <= frisa_pkg::shift_left_logical_op;
    dest_sel_i  <= 1'b1;
    file_data_i <= 8'h80;
    #1;
    chk(acc_o, 8'h07);
    @(posedge clk_sys_i);
    op_code_i   <= frisa_pkg::shift_right_logical_op;
    file_data_i <= 8'h03;
    #1;
    chk(file_wdata_o, 8'h00);
    chk({6'h00, zero_o, carry_o}, 8'h03);
    @(posedge clk_sys_i);
    op_code_i   <= frisa_pkg::increment_file_op;
    file_data_i <= 8'hFF;
    #1;
    chk(file_wdata_o, 8'h01);
    chk({6'h00, zero_o, carry_o}, 8'h01);
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    #1;
    chk(file_wdata_o, 8'h00);
    chk({4'h0, done_o, file_we_o, zero_o, carry_o}, 8'h0F);
    chk(acc_o, 8'h07);
    exp_acc = 8'h07;
    exp_c   = 1'b1;
  endtask : t_back_to_back

  // Mid-run reset: every output drops to zero and stays there after release
  task automatic t_reset();
    run_op(frisa_pkg::shift_left_logical_op, 1'b0, 7'h55, 8'hC1);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk(acc_o, 8'h00);
    chk(file_wdata_o, 8'h00);
    chk({1'b0, file_addr_o}, 8'h00);
    chk({4'h0, file_we_o, done_o, zero_o, carry_o}, 8'h00);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    exp_acc = 8'h00;
    exp_c   = 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(acc_o, 8'h00);
    chk(file_wdata_o, 8'h00);
    chk({4'h0, file_we_o, done_o, zero_o, carry_o}, 8'h00);
  endtask : t_reset

  // Hang guard: the whole sequence takes well under 200 cycles
  initial begin
    #10000;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk(acc_o, 8'h00);
    t_increment();
    t_or();
    t_shift_left();
    t_collide();
    t_back_to_back();
    t_reset();
    t_shift_right();
    finish_test();
  end
endmodule : frisa_datapath_tb
